//--- src/cfg_store.sv
// one state configuration register with masked writes
`timescale 1ns/1ps

module cfg_store #(
	parameter logic [31:0] RESET_VAL = 32'h0000_0000,
	parameter logic [31:0] WMASK = 32'h0000_0000,
	parameter logic [31:0] RO_SET = 32'h0000_0000
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic we,
	input wire logic [31:0] wdata,
	output logic [31:0] value
);

	logic [31:0] value_r;
	logic [31:0] value_nxt;

	// reserved bits forced to zero, read-only bits forced
	always_comb
	begin
		value_nxt = value_r;
		if (we)
		begin
			value_nxt = (wdata & WMASK) | RO_SET;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			value_r <= RESET_VAL;
		end
		else
		begin
			value_r <= value_nxt;
		end
	end

	assign value = value_r;

endmodule : cfg_store

//--- src/dwell_timer.sv
// counts 2^n ticks of the selected sequencer clock
`timescale 1ns/1ps

module dwell_timer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic tick,
	input wire logic [4:0] log2_len,
	output logic done
);

	typedef struct packed {
		logic [31:0] cnt;
		logic done;
	} timer_s;

	timer_s q;
	timer_s d;
	logic [31:0] limit;
	logic [31:0] cnt_eff;

	always_comb
	begin
		d = q;
		limit = (32'h0000_0001 << log2_len) - 32'h0000_0001;
		cnt_eff = q.cnt;
		if (start)
		begin
			cnt_eff = 32'h0000_0000;
			d.done = 1'b0;
			d.cnt = 32'h0000_0000;
		end
		if (tick && !d.done)
		begin
			if (cnt_eff == limit)
			begin
				d.done = 1'b1;
			end
			else
			begin
				d.cnt = cnt_eff + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign done = q.done;

endmodule : dwell_timer

//--- src/power_state_supply_config.sv
// power sequencer with per-state supply configuration, AHB-Lite slave
`timescale 1ns/1ps
`include "power_state_supply_config_regs.svh"

module power_state_supply_config #(
	parameter int SLOW_DIV = `SYS_CLK_HZ / `SLOW_OSC_HZ
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire pssc_pkg::supply_good_s power_good,
	input wire logic wake_req,
	output pssc_pkg::supply_cfg_s supply_out,
	output logic [2:0] seq_state
);

	// ======================================================================
	// state
	typedef struct packed {
		pssc_pkg::seq_state_e st;
		logic enter;
		logic sleep_req;
		logic clk_default_sel;
		logic [12:0] div_cnt;
		logic slow_tick;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic [31:0] hrdata;
		logic hready;
		pssc_pkg::supply_cfg_s supply;
		logic [31:0] ticks_in;
	} top_s;

	top_s q;
	top_s d;

	logic [31:0] ru2_val;
	logic [31:0] fo_val;
	logic [31:0] rd1_val;
	logic [31:0] rd2_val;
	logic we_ru2;
	logic we_fo;
	logic we_rd1;
	logic we_rd2;
	logic tick;
	logic dw_done;
	logic [4:0] dwell_sel;
	logic take;
	logic done_ok;
	logic pg_ok;

	function automatic pssc_pkg::supply_cfg_s decode(input logic [31:0] w);
		pssc_pkg::supply_cfg_s c;
		c.tile_clk_gate = w[`F_TILE_GATE];
		c.analogue_pfm = w[`F_ANALOGUE_PFM];
		c.core_pfm = w[`F_CORE_PFM];
		c.io_supply_output = w[`F_IO_EN];
		c.pll_supply_regulator = w[`F_PLL_EN];
		c.analogue_converter = w[`F_ANALOGUE_EN];
		c.core_converter = w[`F_CORE_EN];
		return c;
	endfunction : decode

	// ======================================================================
	// configuration registers
	cfg_store #(
		.RESET_VAL(`RST_RAMP_UP_SECOND),
		.WMASK(`WMASK_TIMED),
		.RO_SET(`RO_SET_CFG)
	) u_ru2 (
		.clk_sys(clk_sys),
		.rst(rst),
		.we(we_ru2),
		.wdata(hwdata),
		.value(ru2_val)
	);

	cfg_store #(
		.RESET_VAL(`RST_FULLY_ON),
		.WMASK(`WMASK_UNTIMED),
		.RO_SET(`RO_SET_CFG)
	) u_fo (
		.clk_sys(clk_sys),
		.rst(rst),
		.we(we_fo),
		.wdata(hwdata),
		.value(fo_val)
	);

	cfg_store #(
		.RESET_VAL(`RST_RAMP_DOWN_FIRST),
		.WMASK(`WMASK_TIMED),
		.RO_SET(`RO_SET_CFG)
	) u_rd1 (
		.clk_sys(clk_sys),
		.rst(rst),
		.we(we_rd1),
		.wdata(hwdata),
		.value(rd1_val)
	);

	cfg_store #(
		.RESET_VAL(`RST_RAMP_DOWN_SECOND),
		.WMASK(`WMASK_TIMED),
		.RO_SET(`RO_SET_CFG)
	) u_rd2 (
		.clk_sys(clk_sys),
		.rst(rst),
		.we(we_rd2),
		.wdata(hwdata),
		.value(rd2_val)
	);

	// write commit in the data phase
	assign we_ru2 = q.wr_pend && (q.addr == `OFS_RAMP_UP_SECOND);
	assign we_fo = q.wr_pend && (q.addr == `OFS_FULLY_ON);
	assign we_rd1 = q.wr_pend && (q.addr == `OFS_RAMP_DOWN_FIRST);
	assign we_rd2 = q.wr_pend && (q.addr == `OFS_RAMP_DOWN_SECOND);

	// ======================================================================
	// dwell timing
	assign tick = q.clk_default_sel | q.slow_tick;

	always_comb
	begin
		case (q.st)
			pssc_pkg::ST_RAMP_UP_SECOND: dwell_sel = ru2_val[20:16];
			pssc_pkg::ST_RAMP_DOWN_FIRST: dwell_sel = rd1_val[20:16];
			pssc_pkg::ST_RAMP_DOWN_SECOND: dwell_sel = rd2_val[20:16];
			default: dwell_sel = 5'h00;
		endcase
	end

	dwell_timer u_dwell (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(q.enter),
		.tick(tick),
		.log2_len(dwell_sel),
		.done(dw_done)
	);

	// stale done from the previous state is masked on entry
	assign done_ok = dw_done && !q.enter;
	assign pg_ok = (!q.supply.core_converter || power_good.core_converter)
		&& (!q.supply.analogue_converter || power_good.analogue_converter)
		&& (!q.supply.pll_supply_regulator
			|| power_good.pll_supply_regulator)
		&& (!q.supply.io_supply_output || power_good.io_supply_output);

	assign take = hsel && htrans[1] && hready;

	// ======================================================================
	// next state
	always_comb
	begin
		d = q;
		// slow oscillator tick from the divider
		d.slow_tick = 1'b0;
		if (q.div_cnt == 13'(SLOW_DIV - 1))
		begin
			d.div_cnt = 13'h0000;
			d.slow_tick = 1'b1;
		end
		else
			d.div_cnt = q.div_cnt + 13'h0001;

		// sequencer; a pending request dies once fully-on is left
		if (q.st != pssc_pkg::ST_FULLY_ON)
			d.sleep_req = 1'b0;
		case (q.st)
			pssc_pkg::ST_RESET: d.st = pssc_pkg::ST_RAMP_UP_FIRST;
			pssc_pkg::ST_ASLEEP:
				if (wake_req)
					d.st = pssc_pkg::ST_RAMP_UP_FIRST;
			pssc_pkg::ST_RAMP_UP_FIRST: d.st = pssc_pkg::ST_RAMP_UP_SECOND;
			pssc_pkg::ST_RAMP_UP_SECOND:
				if (done_ok && pg_ok)
					d.st = pssc_pkg::ST_AWAKE_WAIT;
			pssc_pkg::ST_AWAKE_WAIT: d.st = pssc_pkg::ST_FULLY_ON;
			pssc_pkg::ST_FULLY_ON:
				if (q.sleep_req)
					d.st = pssc_pkg::ST_RAMP_DOWN_FIRST;
			pssc_pkg::ST_RAMP_DOWN_FIRST:
				if (done_ok)
					d.st = pssc_pkg::ST_RAMP_DOWN_SECOND;
			pssc_pkg::ST_RAMP_DOWN_SECOND:
				if (done_ok)
					d.st = pssc_pkg::ST_ASLEEP;
			default: d.st = pssc_pkg::ST_RESET;
		endcase
		d.enter = (d.st != q.st);

		// supplies for the state being entered or held
		case (d.st)
			pssc_pkg::ST_RAMP_UP_SECOND: d.supply = decode(ru2_val);
			pssc_pkg::ST_AWAKE_WAIT: d.supply = decode(ru2_val);
			pssc_pkg::ST_FULLY_ON: d.supply = decode(fo_val);
			pssc_pkg::ST_RAMP_DOWN_FIRST: d.supply = decode(rd1_val);
			pssc_pkg::ST_RAMP_DOWN_SECOND: d.supply = decode(rd2_val);
			default: d.supply = decode(`RO_SET_CFG);
		endcase

		// ticks seen since entry, for checking the dwell
		if (q.enter)
			d.ticks_in = {31'h0000_0000, tick};
		else
			d.ticks_in = q.ticks_in + {31'h0000_0000, tick};

		// bus: writes commit in the data phase
		if (q.wr_pend && (q.addr == `OFS_CONTROL))
		begin
			d.clk_default_sel = hwdata[`F_CTRL_CLK_DEFAULT];
			if (hwdata[`F_CTRL_SLEEP_REQ] && q.st == pssc_pkg::ST_FULLY_ON)
				d.sleep_req = 1'b1;
		end
		// reads take one wait state so earlier writes are visible
		if (q.rd_pend)
		begin
			d.hready = 1'b1;
			case (q.addr)
				`OFS_CONTROL: d.hrdata = {31'h0000_0000, q.clk_default_sel};
				`OFS_RAMP_UP_SECOND: d.hrdata = ru2_val;
				`OFS_FULLY_ON: d.hrdata = fo_val;
				`OFS_RAMP_DOWN_FIRST: d.hrdata = rd1_val;
				`OFS_RAMP_DOWN_SECOND: d.hrdata = rd2_val;
				`OFS_STATUS:
				begin
					d.hrdata = 32'h0000_0000;
					d.hrdata[`F_STATE_HI:`F_STATE_LO] = q.st;
					d.hrdata[`F_TILE_GATE] = q.supply.tile_clk_gate;
					d.hrdata[`F_ANALOGUE_PFM] = q.supply.analogue_pfm;
					d.hrdata[`F_CORE_PFM] = q.supply.core_pfm;
					d.hrdata[`F_IO_EN] = q.supply.io_supply_output;
					d.hrdata[`F_PLL_EN] = q.supply.pll_supply_regulator;
					d.hrdata[`F_ANALOGUE_EN] = q.supply.analogue_converter;
					d.hrdata[`F_CORE_EN] = q.supply.core_converter;
				end
				default: d.hrdata = 32'h0000_0000;
			endcase
		end
		d.wr_pend = take && hwrite;
		d.rd_pend = take && !hwrite;
		if (take)
			d.addr = haddr[7:0];
		if (take && !hwrite)
			d.hready = 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			q <= '0;
			q.st <= pssc_pkg::ST_RESET;
			q.hready <= 1'b1;
			q.supply <= '0;
			q.supply.analogue_converter <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	assign hrdata = q.hrdata;
	assign hreadyout = q.hready;
	assign hresp = 1'b0;
	assign supply_out = q.supply;
	assign seq_state = q.st;

	// ======================================================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	AST_RU2_APPLIED: assert property (
		q.st == pssc_pkg::ST_RAMP_UP_SECOND && $past(q.st) == q.st
		|-> q.supply == decode($past(ru2_val)))
		else $error("ramp-up-second supplies differ from register");
	AST_ADVANCE_GOOD: assert property (
		$past(q.st) == pssc_pkg::ST_RAMP_UP_SECOND
		&& q.st != pssc_pkg::ST_RAMP_UP_SECOND
		|-> $past(pg_ok) && $past(done_ok)
		&& q.st == pssc_pkg::ST_AWAKE_WAIT)
		else $error("left ramp-up-second early or without power good");
	AST_DWELL_EXACT: assert property (
		q.st == pssc_pkg::ST_RAMP_DOWN_FIRST && done_ok
		&& !$past(dw_done)
		|-> q.ticks_in == (32'h0000_0001 << rd1_val[20:16]))
		else $error("ramp-down-first dwell tick count wrong");
	AST_DWELL_RESET: assert property (
		$past(rst) |-> ru2_val[20:16] == `RST_DWELL
		&& rd1_val[20:16] == `RST_DWELL && rd2_val[20:16] == `RST_DWELL)
		else $error("dwell field reset value wrong");
	AST_TILE_GATE: assert property (
		q.st == pssc_pkg::ST_FULLY_ON && $past(q.st) == q.st
		|-> q.supply.tile_clk_gate == $past(fo_val[`F_TILE_GATE])
		&& q.supply.core_pfm == $past(fo_val[`F_CORE_PFM]))
		else $error("fully-on tile gate or modulation not applied");
	AST_ANALOGUE_RO: assert property (
		ru2_val[1] && fo_val[1] && rd1_val[1] && rd2_val[1]
		&& (ru2_val & ~`WMASK_TIMED & ~`RO_SET_CFG) == 32'h0000_0000)
		else $error("read-only or reserved bit wrong");
	AST_SLEEP_FROM_FO: assert property (
		q.st == pssc_pkg::ST_RAMP_DOWN_FIRST
		&& $past(q.st) != pssc_pkg::ST_RAMP_DOWN_FIRST
		|-> $past(q.st) == pssc_pkg::ST_FULLY_ON)
		else $error("ramp-down entered from a state other than fully-on");
	AST_DOWN_ORDER: assert property (
		$past(q.st) == pssc_pkg::ST_RAMP_DOWN_SECOND
		&& q.st != pssc_pkg::ST_RAMP_DOWN_SECOND
		|-> q.st == pssc_pkg::ST_ASLEEP ##1 q.supply.analogue_converter)
		else $error("ramp-down-second did not lead to asleep");
	AST_FO_DEFAULT: assert property (
		$past(rst) |-> fo_val == `RST_FULLY_ON
		&& ru2_val == `RST_RAMP_UP_SECOND)
		else $error("fully-on or ramp-up-second reset value wrong");
	AST_READ_WAIT: assert property (
		take && !hwrite && haddr[7:0] >= `OFS_RAMP_UP_SECOND
		&& haddr[7:0] <= `OFS_RAMP_DOWN_SECOND
		|=> !hreadyout ##1 (hreadyout && hrdata[31:21] == 11'h000
		&& hrdata[15] == 1'b0 && hrdata[13:10] == 4'h0
		&& hrdata[7:6] == 2'h0 && hrdata[3:2] == 2'h0))
		else $error("configuration read wait or reserved bits wrong");

endmodule : power_state_supply_config

//--- src/power_state_supply_config_regs.svh
// register offsets, field positions, reset values and clock frequencies
`ifndef POWER_STATE_SUPPLY_CONFIG_REGS_SVH
`define POWER_STATE_SUPPLY_CONFIG_REGS_SVH

// ==========================================================================
// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_RAMP_UP_SECOND 8'h14
`define OFS_FULLY_ON 8'h18
`define OFS_RAMP_DOWN_FIRST 8'h1C
`define OFS_RAMP_DOWN_SECOND 8'h20
`define OFS_STATUS 8'h24

// ==========================================================================
// field positions
`define F_CORE_EN 0
`define F_ANALOGUE_EN 1
`define F_PLL_EN 4
`define F_IO_EN 5
`define F_CORE_PFM 8
`define F_ANALOGUE_PFM 9
`define F_TILE_GATE 14
`define F_DWELL_LO 16
`define F_DWELL_HI 20
`define F_STATE_LO 16
`define F_STATE_HI 18
`define F_CTRL_CLK_DEFAULT 0
`define F_CTRL_SLEEP_REQ 1

// ==========================================================================
// reset values and write masks
`define RST_DWELL 5'h10
`define RST_RAMP_UP_SECOND 32'h0010_0033
`define RST_FULLY_ON 32'h0000_0033
`define RST_RAMP_DOWN_FIRST 32'h0010_0022
`define RST_RAMP_DOWN_SECOND 32'h0010_0002
`define WMASK_TIMED 32'h001F_4331
`define WMASK_UNTIMED 32'h0000_4331
`define RO_SET_CFG 32'h0000_0002

// ==========================================================================
// timing
`define SYS_CLK_HZ 200000000
`define SLOW_OSC_HZ 31250

`endif

//--- src/pssc_pkg.sv
// types shared by the supply configuration sequencer
package pssc_pkg;

	typedef enum logic [2:0] {
		ST_RESET,
		ST_ASLEEP,
		ST_RAMP_UP_FIRST,
		ST_RAMP_UP_SECOND,
		ST_AWAKE_WAIT,
		ST_FULLY_ON,
		ST_RAMP_DOWN_FIRST,
		ST_RAMP_DOWN_SECOND
	} seq_state_e;

	typedef struct packed {
		logic tile_clk_gate;
		logic analogue_pfm;
		logic core_pfm;
		logic io_supply_output;
		logic pll_supply_regulator;
		logic analogue_converter;
		logic core_converter;
	} supply_cfg_s;

	typedef struct packed {
		logic io_supply_output;
		logic pll_supply_regulator;
		logic analogue_converter;
		logic core_converter;
	} supply_good_s;

endpackage : pssc_pkg

//--- verif/power_state_supply_config_test.sv
// self-checking bench for the per-state supply configuration sequencer
`timescale 1ns/1ps

module power_state_supply_config_test;
	// ==========================================================
	// clock, reset and design hookup
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	pssc_pkg::supply_good_s power_good = 4'h0;
	logic wake_req = 1'b0;
	pssc_pkg::supply_cfg_s supply_out;
	logic [2:0] seq_state;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] rd;
	int n;

	always #2.5 clk_sys = ~clk_sys;
	assign hready = hreadyout;

	power_state_supply_config #(.SLOW_DIV(4)) power_state_supply_config_inst (
		.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .power_good(power_good), .wake_req(wake_req),
		.supply_out(supply_out), .seq_state(seq_state)
	);

	// ==========================================================
	// reporting
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// hang guard, sized for one full default dwell plus margin
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			errors++;
			final_report();
		end
	end

	// ==========================================================
	// bus master, single word transfers
	task automatic ahb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		r = hrdata;
		check({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(a, 1'b1, d, r);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		ahb(a, 1'b0, 32'h0000_0000, rd);
		check(rd, e);
	endtask : rd_chk

	task automatic wait_state(input logic [2:0] s, input int lim);
		n = 0;
		while (seq_state !== s && n < lim)
		begin
			@(posedge clk_sys);
			n++;
		end
		check({29'h0, seq_state}, {29'h0, s});
	endtask : wait_state

	// cycles spent in the current state, counted edge by edge
	task automatic dwell_len(input logic [2:0] s);
		n = 0;
		while (seq_state === s && n < 200)
		begin
			@(posedge clk_sys);
			n++;
		end
	endtask : dwell_len

	// ==========================================================
	// scenarios
	task automatic t_reset_vals;
		wait_state(3'h3, 10);
		check({25'h0, supply_out}, 32'h0000_000F);
		rd_chk(8'h14, 32'h0010_0033);
		rd_chk(8'h18, 32'h0000_0033);
		rd_chk(8'h1C, 32'h0010_0022);
		rd_chk(8'h20, 32'h0010_0002);
		rd_chk(8'h24, 32'h0003_0033);
		$display("test reset values done");
	endtask : t_reset_vals

	task automatic t_masks;
		wr(8'h18, 32'hFFFF_FFFF);
		rd_chk(8'h18, 32'h0000_4333);
		wr(8'h20, 32'h0000_0000);
		rd_chk(8'h20, 32'h0000_0002);
		wr(8'h20, 32'hFFFF_FFFF);
		rd_chk(8'h20, 32'h001F_4333);
		wr(8'h28, 32'hFFFF_FFFF);
		rd_chk(8'h28, 32'h0000_0000);
		$display("test masks done");
	endtask : t_masks

	task automatic t_first_wake;
		wr(8'h00, 32'h0000_0001);
		power_good <= 4'h7;
		repeat (66000) @(posedge clk_sys);
		check({29'h0, seq_state}, 32'h0000_0003);
		power_good <= 4'hF;
		wait_state(3'h4, 10);
		wait_state(3'h5, 3);
		check({25'h0, supply_out}, 32'h0000_007F);
		wr(8'h18, 32'h0000_4301);
		repeat (2) @(posedge clk_sys);
		check({25'h0, supply_out}, 32'h0000_0073);
		rd_chk(8'h24, 32'h0005_4303);
		$display("test first wake done");
	endtask : t_first_wake

	task automatic t_sleep;
		wr(8'h1C, 32'h0002_0022);
		wr(8'h20, 32'h0003_4002);
		wr(8'h14, 32'h0001_0221);
		wr(8'h00, 32'h0000_0003);
		wait_state(3'h6, 6);
		check({25'h0, supply_out}, 32'h0000_000A);
		dwell_len(3'h6);
		check(n, 32'h0000_0005);
		check({25'h0, supply_out}, 32'h0000_0042);
		dwell_len(3'h7);
		check(n, 32'h0000_0009);
		check({29'h0, seq_state}, 32'h0000_0001);
		rd_chk(8'h00, 32'h0000_0001);
		wr(8'h00, 32'h0000_0003);
		repeat (20) @(posedge clk_sys);
		check({29'h0, seq_state}, 32'h0000_0001);
		$display("test sleep done");
	endtask : t_sleep

	task automatic t_second_wake;
		power_good <= 4'hB;
		wake_req <= 1'b1;
		wait_state(3'h2, 6);
		wait_state(3'h3, 3);
		wake_req <= 1'b0;
		check({25'h0, supply_out}, 32'h0000_002B);
		dwell_len(3'h3);
		check(n, 32'h0000_0003);
		check({29'h0, seq_state}, 32'h0000_0004);
		wait_state(3'h5, 3);
		$display("test second wake done");
	endtask : t_second_wake

	task automatic t_slow_tick;
		wr(8'h00, 32'h0000_0002);
		wait_state(3'h6, 6);
		dwell_len(3'h6);
		check({31'h0, (n >= 13 && n <= 21)}, 32'h0000_0001);
		$display("test slow tick done");
	endtask : t_slow_tick

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset_vals();
		t_masks();
		t_first_wake();
		t_sleep();
		t_second_wake();
		t_slow_tick();
		final_report();
	end
endmodule : power_state_supply_config_test
